// >>> design/tx_regs.sv
// Transmit buffer pointers, pause quantum and transmit status registers on AHB-Lite
//
// Contract
// RULE_01: Pause quantum is sixteen bits from host read/write high and low byte registers.
// RULE_02: Pause quantum counts units of 512 bit times inside the sent PAUSE packet.
// RULE_03: Host starts each packet at buffer address zero; start pointer holds that start. Code advances it by one on each append instead.
// RULE_04: Device keeps a split end pointer naming the last byte added.
// RULE_05: Each write to the append port adds exactly one byte to the buffer.
// RULE_06: Each append sets the end pointer to the address being written.
// RULE_07: Top status register holds vector bits 51..48 low; upper nibble reads zero.
// RULE_08: Status bit 3 reports length/type 0x8100; zero means it was.
// RULE_09: Status bit 2 set when back pressure was applied during last transmission.
// RULE_10: Status bit 1 set only for a valid PAUSE control frame.
// RULE_11: Status bit 0 set when last frame was a control frame.
// RULE_12: Sixteen-bit wire byte total, collided bytes included, high then low register.
// RULE_13: Abort register holds vector bits 31..24; bit 7 marks under-run abort.
// RULE_14: Abort bit 6 set for oversized frame abort, clear otherwise.
// RULE_15: Abort bit 5 set for a collision after the collision window.
// RULE_16: Abort bit 4 set after sixteen or more collisions, clear otherwise.
// RULE_17: Abort bit 3 set when deferral exceeded the long limit.
// RULE_18: Abort bit 2 set when sent after short delay; clear if none or aborted.
// RULE_19: Abort bit 1 set when last packet had a broadcast destination.
// RULE_20: Abort bit 0 set when last packet had a multicast destination.
// RULE_21: Writing one to go bit starts sending the buffered packet.
// RULE_22: Pause packet bit makes the device send PAUSE without reading the buffer.
// RULE_23: Each append also advances the start pointer.
// RULE_24: All status fields are captured together at attempt end and then held.
`timescale 1ns/1ps
module tx_regs
    import tx_regs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // MAC status levels, valid with the done pulse
    input wire logic mac_tx_done,
    input wire logic mac_vlan_frame,
    input wire logic mac_backpressure_used,
    input wire logic mac_pause_frame,
    input wire logic mac_control_frame,
    input wire logic [15:0] mac_wire_bytes,
    input wire logic mac_underrun,
    input wire logic mac_oversize,
    input wire logic mac_late_collision,
    input wire logic mac_excess_collision,
    input wire logic mac_excess_deferral,
    input wire logic mac_deferred,
    input wire logic mac_broadcast,
    input wire logic mac_multicast,
    // Buffer write port and transmit requests
    output logic buf_write,
    output logic [15:0] buf_addr,
    output logic [7:0] buf_data,
    output logic send_go_bit,
    output logic pause_packet_request,
    output logic backpressure_request,
    output logic [15:0] pause_quantum
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        // Host-written bytes and pointers
        logic [7:0] pause_quantum_high;
        logic [7:0] pause_quantum_low;
        logic [15:0] start_pointer;
        logic [15:0] end_pointer;
        // Transmit control and captured status
        logic pause_sel;
        logic backpressure_sel;
        tx_state_e tx_state;
        logic [3:0] frame_kind;
        logic [15:0] wire_bytes;
        logic [7:0] abort_flags;
        // Write address held over for its data phase
        logic wr_pending;
        logic [6:0] wr_index;
        logic wr_valid;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        // Registered copies of the outputs
        logic buf_write;
        logic [15:0] buf_addr;
        logic [7:0] buf_data;
        logic go;
        logic pause_req;
        logic bp_req;
    } regs_s;

    regs_s s;
    regs_s next_s;

    // Word index of a bus address; misaligned or out-of-range reads as unmapped
    function automatic logic [7:0] decode_index(input logic [31:0] addr);
        logic mapped;
        mapped = (addr[31:ADDR_IDX_MSB + 1] == '0) && (addr[ADDR_IDX_LSB - 1:0] == '0);
        decode_index = {mapped, addr[ADDR_IDX_MSB:ADDR_IDX_LSB]};
    endfunction

    // Byte seen by a read at the given index
    function automatic logic [7:0] read_byte(input regs_s r, input logic [6:0] idx);
        logic [7:0] v;
        v = RESET_BYTE;
        unique case (idx)
            // Go is a strobe and reads back as zero
            IDX_TX_CONTROL: begin
                v[CTRL_PAUSE_BIT] = r.pause_sel;
                v[CTRL_BACKPRESSURE_BIT] = r.backpressure_sel;
            end
            IDX_PAUSE_HIGH: v = r.pause_quantum_high; // [RULE_01]
            IDX_PAUSE_LOW: v = r.pause_quantum_low; // [RULE_01]
            IDX_END_HIGH: v = r.end_pointer[15:8]; // [RULE_04]
            IDX_END_LOW: v = r.end_pointer[7:0]; // [RULE_04]
            IDX_START_HIGH: v = r.start_pointer[15:8];
            IDX_START_LOW: v = r.start_pointer[7:0];
            IDX_FRAME_KIND: v = {4'h0, r.frame_kind}; // [RULE_07]
            IDX_WIRE_HIGH: v = r.wire_bytes[15:8]; // [RULE_12]
            IDX_WIRE_LOW: v = r.wire_bytes[7:0]; // [RULE_12]
            IDX_ABORT_FLAGS: v = r.abort_flags; // [RULE_13]
            default: v = RESET_BYTE;
        endcase
        read_byte = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Write data phase is applied before the read mux, so a read right behind
    // a write sees the new value without a wait state
    always_comb begin
        logic [7:0] dec;
        logic [7:0] wbyte;
        logic aborted;
        dec = decode_index(haddr);
        wbyte = hwdata[7:0];
        aborted = 1'b0;
        // Hold everything unless a rule below moves it
        next_s = s;
        // Strobes last one cycle; the bus never stalls
        next_s.buf_write = 1'b0;
        next_s.go = 1'b0;
        next_s.ready = 1'b1;
        next_s.resp = HRESP_OKAY;

        // Data phase of a pending write
        if (s.wr_pending && s.wr_valid) begin
            unique case (s.wr_index)
                IDX_APPEND: begin
                    next_s.buf_write = 1'b1; // [RULE_05]
                    next_s.buf_addr = s.start_pointer;
                    next_s.buf_data = wbyte;
                    next_s.end_pointer = s.start_pointer; // [RULE_06]
                    next_s.start_pointer = s.start_pointer + POINTER_STEP; // [RULE_23]
                end
                IDX_TX_CONTROL: begin
                    next_s.pause_sel = wbyte[CTRL_PAUSE_BIT];
                    next_s.backpressure_sel = wbyte[CTRL_BACKPRESSURE_BIT];
                    // Go while a send is running is dropped; the MAC has one job
                    if (wbyte[CTRL_GO_BIT] && s.tx_state == TX_IDLE) begin
                        next_s.go = 1'b1; // [RULE_21]
                        next_s.pause_req = wbyte[CTRL_PAUSE_BIT]; // [RULE_22]
                        next_s.bp_req = wbyte[CTRL_BACKPRESSURE_BIT];
                        next_s.tx_state = TX_BUSY;
                    end
                end
                IDX_PAUSE_HIGH: next_s.pause_quantum_high = wbyte; // [RULE_01]
                IDX_PAUSE_LOW: next_s.pause_quantum_low = wbyte; // [RULE_01]
                // Host may also set the pointers by hand
                IDX_END_HIGH: next_s.end_pointer[15:8] = wbyte;
                IDX_END_LOW: next_s.end_pointer[7:0] = wbyte;
                IDX_START_HIGH: next_s.start_pointer[15:8] = wbyte; // [RULE_03]
                IDX_START_LOW: next_s.start_pointer[7:0] = wbyte; // [RULE_03]
                default: ;
            endcase
        end

        // Transmission end: capture every status field at once and hold it
        if (mac_tx_done && s.tx_state == TX_BUSY) begin
            next_s.tx_state = TX_IDLE;
            next_s.pause_req = 1'b0;
            next_s.bp_req = 1'b0;
            next_s.frame_kind[KIND_VLAN_BIT] = !mac_vlan_frame; // [RULE_08] [RULE_24]
            next_s.frame_kind[KIND_BACKPRESSURE_BIT] = mac_backpressure_used; // [RULE_09]
            next_s.frame_kind[KIND_PAUSE_BIT] = mac_pause_frame && mac_control_frame; // [RULE_10]
            next_s.frame_kind[KIND_CONTROL_BIT] = mac_control_frame; // [RULE_11]
            next_s.wire_bytes = mac_wire_bytes; // [RULE_12]
            // Any abort clears the plain delay flag
            aborted = mac_underrun || mac_oversize || mac_late_collision
                || mac_excess_collision || mac_excess_deferral;
            next_s.abort_flags[ABORT_UNDERRUN_BIT] = mac_underrun; // [RULE_13]
            next_s.abort_flags[ABORT_OVERSIZE_BIT] = mac_oversize; // [RULE_14]
            next_s.abort_flags[ABORT_LATE_COLL_BIT] = mac_late_collision; // [RULE_15]
            next_s.abort_flags[ABORT_EXCESS_COLL_BIT] = mac_excess_collision; // [RULE_16]
            next_s.abort_flags[ABORT_EXCESS_DEFER_BIT] = mac_excess_deferral; // [RULE_17]
            next_s.abort_flags[ABORT_DEFER_BIT] = mac_deferred && !aborted; // [RULE_18]
            next_s.abort_flags[ABORT_BROADCAST_BIT] = mac_broadcast; // [RULE_19]
            next_s.abort_flags[ABORT_MULTICAST_BIT] = mac_multicast; // [RULE_20]
        end

        // Address phase
        next_s.wr_pending = 1'b0;
        if (hsel && htrans[HTRANS_ACTIVE_BIT] && hready) begin
            next_s.wr_pending = hwrite;
            next_s.wr_index = dec[6:0];
            next_s.wr_valid = dec[7];
            next_s.rdata = '0;
            // Unmapped or misaligned words read zero
            if (!hwrite && dec[7]) begin
                next_s.rdata = {24'h00_0000, read_byte(next_s, dec[6:0])};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Clock enable low freezes everything, bus answer included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{
                pause_quantum_high: RESET_BYTE,
                pause_quantum_low: RESET_BYTE,
                start_pointer: RESET_POINTER,
                end_pointer: RESET_POINTER,
                pause_sel: 1'b0,
                backpressure_sel: 1'b0,
                tx_state: TX_IDLE,
                frame_kind: RESET_KIND,
                wire_bytes: RESET_POINTER,
                abort_flags: RESET_BYTE,
                wr_pending: 1'b0,
                wr_index: '0,
                wr_valid: 1'b0,
                rdata: '0,
                ready: 1'b1,
                resp: HRESP_OKAY,
                buf_write: 1'b0,
                buf_addr: RESET_POINTER,
                buf_data: RESET_BYTE,
                go: 1'b0,
                pause_req: 1'b0,
                bp_req: 1'b0
            };
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Outputs straight from the state flops
    assign hrdata = s.rdata;
    assign hreadyout = s.ready;
    assign hresp = s.resp;

    // Buffer port
    assign buf_write = s.buf_write;
    assign buf_addr = s.buf_addr;
    assign buf_data = s.buf_data;

    // Transmit requests
    assign send_go_bit = s.go;
    assign pause_packet_request = s.pause_req;
    assign backpressure_request = s.bp_req;
    // Quantum goes to the MAC raw; it scales by the unit of PAUSE_UNIT_BIT_TIMES
    assign pause_quantum = {s.pause_quantum_high, s.pause_quantum_low}; // [RULE_02]

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    // Checks tick on the enabled clock, except a_ce_freeze on the raw clock; all rest in reset
    default clocking cb @(posedge hclk iff ce);
    endclocking
    default disable iff (!hresetn);

    // Address-phase decodes for the checks below
    logic append_addr_phase;
    logic pq_high_addr_phase;
    logic go_addr_phase;
    assign append_addr_phase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && hwrite
        && decode_index(haddr) == {1'b1, IDX_APPEND};
    assign pq_high_addr_phase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && hwrite
        && decode_index(haddr) == {1'b1, IDX_PAUSE_HIGH};
    assign go_addr_phase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && hwrite
        && decode_index(haddr) == {1'b1, IDX_TX_CONTROL} && s.tx_state == TX_IDLE;

    // One append, one strobe, carrying the written byte
    a_append_one_byte: assert property ( // [RULE_05]
        append_addr_phase |=> ##1 (buf_write && buf_data == $past(hwdata[7:0]))
        ##1 !buf_write || $past(s.wr_pending))
        else $error("append write did not give one buffer strobe");

    // End pointer names the byte on the port
    a_end_follows: assert property ( // [RULE_06]
        buf_write |-> (s.end_pointer == buf_addr))
        else $error("end pointer not at written byte");

    // Start pointer steps once per append
    a_start_advances: assert property ( // [RULE_23]
        append_addr_phase |=> ##1 (s.start_pointer == $past(s.start_pointer) + POINTER_STEP))
        else $error("start pointer did not advance on append");

    // High quantum byte lands from the low lane
    a_pause_high: assert property ( // [RULE_01]
        pq_high_addr_phase |=> ##1 (pause_quantum[15:8] == $past(hwdata[7:0])))
        else $error("pause quantum high byte not written");

    // Status moves only at the end of a send
    a_status_hold: assert property ( // [RULE_24]
        !$past(mac_tx_done) |-> ($stable(s.abort_flags) && $stable(s.wire_bytes)
        && $stable(s.frame_kind)))
        else $error("status changed without a transmission end");

    // Delay flag never shares the word with an abort
    a_defer_clear: assert property ( // [RULE_18]
        s.abort_flags[ABORT_DEFER_BIT] |-> (s.abort_flags[7:3] == 5'b0_0000))
        else $error("delay flag set with an abort flag");

    // Go from idle gives a single start pulse
    a_go_pulse: assert property ( // [RULE_21]
        go_addr_phase ##1 (hwdata[CTRL_GO_BIT] && s.wr_valid) |=> send_go_bit ##1 !send_go_bit)
        else $error("go write did not give a one-cycle start");

    // A PAUSE frame is always a control frame
    a_pause_bit: assert property ( // [RULE_10]
        s.frame_kind[KIND_PAUSE_BIT] |-> s.frame_kind[KIND_CONTROL_BIT])
        else $error("pause flag without control flag");

    // Zero wait states and no error answer
    a_bus_okay: assert property (
        hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready and okay");

    // A start pulse only leaves an idle bank
    a_go_when_idle: assert property ( // [RULE_21]
        send_go_bit |-> (s.tx_state == TX_BUSY && $past(s.tx_state) == TX_IDLE))
        else $error("start pulse while a send was running");

    // Pause request lives only while a send runs
    a_req_in_busy: assert property ( // [RULE_22]
        pause_packet_request |-> s.tx_state == TX_BUSY)
        else $error("pause request outside a send");

    // Enable low must leave every flop alone
    a_ce_freeze: assert property (@(posedge hclk) !ce |=> $stable(s))
        else $error("state moved with the clock enable low");

    // Byte total is taken at the end of a send
    a_done_capture: assert property ( // [RULE_12]
        (mac_tx_done && s.tx_state == TX_BUSY) |=> s.wire_bytes == $past(mac_wire_bytes))
        else $error("wire byte total not taken at the end of a send");

    // Every register sits in the low byte lane
    a_rdata_lanes: assert property (hrdata[31:8] == '0)
        else $error("read data outside the low byte lane");

    // Main scenarios reached by the bench
    c_append: cover property (append_addr_phase ##2 buf_write);
    c_pause_send: cover property (send_go_bit && pause_packet_request);
    c_abort_seen: cover property (mac_tx_done && s.tx_state == TX_BUSY && mac_underrun);
    c_delay_seen: cover property (s.abort_flags[ABORT_DEFER_BIT]);

endmodule // tx_regs

// >>> include/tx_regs_pkg.sv
// Constants and types shared by the transmit register bank
package tx_regs_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [6:0] IDX_APPEND = 7'h03;
    localparam logic [6:0] IDX_TX_CONTROL = 7'h53;
    localparam logic [6:0] IDX_PAUSE_HIGH = 7'h55;
    localparam logic [6:0] IDX_PAUSE_LOW = 7'h56;
    localparam logic [6:0] IDX_END_HIGH = 7'h57;
    localparam logic [6:0] IDX_END_LOW = 7'h58;
    localparam logic [6:0] IDX_START_HIGH = 7'h59;
    localparam logic [6:0] IDX_START_LOW = 7'h5a;
    localparam logic [6:0] IDX_FRAME_KIND = 7'h5c;
    localparam logic [6:0] IDX_WIRE_HIGH = 7'h5d;
    localparam logic [6:0] IDX_WIRE_LOW = 7'h5e;
    localparam logic [6:0] IDX_ABORT_FLAGS = 7'h5f;

    // Bus address split: word index sits above the byte lane bits
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 8;

    // Reset values and the append pointer step
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_POINTER = 16'h0000;
    localparam logic [3:0] RESET_KIND = 4'h0;
    localparam logic [15:0] POINTER_STEP = 16'h0001;

    // Transmit control bit positions
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_BACKPRESSURE_BIT = 2;
    localparam int CTRL_PAUSE_BIT = 3;

    // Frame kind flags, low nibble of the top status register
    localparam int KIND_VLAN_BIT = 3;
    localparam int KIND_BACKPRESSURE_BIT = 2;
    localparam int KIND_PAUSE_BIT = 1;
    localparam int KIND_CONTROL_BIT = 0;

    // Abort and delay flags
    localparam int ABORT_UNDERRUN_BIT = 7;
    localparam int ABORT_OVERSIZE_BIT = 6;
    localparam int ABORT_LATE_COLL_BIT = 5;
    localparam int ABORT_EXCESS_COLL_BIT = 4;
    localparam int ABORT_EXCESS_DEFER_BIT = 3;
    localparam int ABORT_DEFER_BIT = 2;
    localparam int ABORT_BROADCAST_BIT = 1;
    localparam int ABORT_MULTICAST_BIT = 0;

    // Pause quantum unit in bit times; only the raw quantum goes to the MAC
    localparam int PAUSE_UNIT_BIT_TIMES = 512;

    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_BUSY = 1'b1
    } tx_state_e;
endpackage

// >>> test/mac_model.sv
// Behavioural model of the MAC that sits behind the transmit register bank
`timescale 1ns/1ps
module mac_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic send_go_bit,
    input wire logic [7:0] latency,
    input wire logic [11:0] plan_flags,
    input wire logic [15:0] plan_bytes,
    output logic mac_tx_done,
    output logic [11:0] status_flags,
    output logic [15:0] mac_wire_bytes
);
    logic busy;
    logic [7:0] count;

    ////////////////////////////////////////////////////////////////////////////////
    // One attempt per go pulse; a go while busy is ignored, as the real MAC would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            count <= 8'h00;
            mac_tx_done <= 1'b0;
        end else begin
            mac_tx_done <= 1'b0;
            if (!busy && send_go_bit) begin
                busy <= 1'b1;
                count <= latency;
            end else if (busy) begin
                if (count <= 8'h01) begin
                    busy <= 1'b0;
                    mac_tx_done <= 1'b1;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end

    // Status is valid only with the done pulse; otherwise inverted so a bank that
    // fails to hold its capture shows a wrong value rather than a lucky one
    assign status_flags = mac_tx_done ? plan_flags : ~plan_flags;
    assign mac_wire_bytes = mac_tx_done ? plan_bytes : ~plan_bytes;
endmodule // mac_model

// >>> test/tb_eth_tx_buffer_pause_status_regs.sv
// Self-checking bench for the transmit register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_eth_tx_buffer_pause_status_regs;
    import tx_regs_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic mac_tx_done;
    logic [11:0] status_flags;
    logic [11:0] plan_flags = 12'h000;
    logic [15:0] plan_bytes = 16'h0000;
    logic [15:0] mac_wire_bytes;
    logic [7:0] latency = 8'h01;
    logic buf_write;
    logic [15:0] buf_addr;
    logic [7:0] buf_data;
    logic send_go_bit;
    logic pause_packet_request;
    logic backpressure_request;
    logic [15:0] pause_quantum;
    logic [15:0] cap_addr[$];
    logic [7:0] cap_data[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int n_go = 0;
    int cycles = 0;
    logic [11:0] cases[14] = '{12'h800, 12'h400, 12'h300, 12'h200, 12'h100, 12'h080, 12'h040,
        12'h020, 12'h010, 12'h008, 12'h004, 12'h00C, 12'h002, 12'h001};

    always #2 hclk = ~hclk;

    tx_regs tx_regs_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mac_tx_done(mac_tx_done), .mac_vlan_frame(status_flags[11]),
        .mac_backpressure_used(status_flags[10]), .mac_pause_frame(status_flags[9]),
        .mac_control_frame(status_flags[8]), .mac_wire_bytes(mac_wire_bytes),
        .mac_underrun(status_flags[7]), .mac_oversize(status_flags[6]),
        .mac_late_collision(status_flags[5]), .mac_excess_collision(status_flags[4]),
        .mac_excess_deferral(status_flags[3]), .mac_deferred(status_flags[2]),
        .mac_broadcast(status_flags[1]), .mac_multicast(status_flags[0]),
        .buf_write(buf_write), .buf_addr(buf_addr), .buf_data(buf_data),
        .send_go_bit(send_go_bit), .pause_packet_request(pause_packet_request),
        .backpressure_request(backpressure_request), .pause_quantum(pause_quantum));

    mac_model mac_model_inst (.hclk(hclk), .hresetn(hresetn), .send_go_bit(send_go_bit),
        .latency(latency), .plan_flags(plan_flags), .plan_bytes(plan_bytes),
        .mac_tx_done(mac_tx_done), .status_flags(status_flags),
        .mac_wire_bytes(mac_wire_bytes));

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer writes and go pulses are one cycle wide, so they are logged every edge
    always @(posedge hclk) begin
        if (buf_write === 1'b1) begin
            cap_addr.push_back(buf_addr);
            cap_data.push_back(buf_data);
        end
        if (send_go_bit === 1'b1) begin
            n_go++;
        end
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One single AHB transfer; waits on hready rather than assuming zero wait states
    task automatic bus_xfer(input logic [6:0] idx, input logic wr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {23'h00_0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic wr8(input logic [6:0] idx, input logic [7:0] data);
        logic [31:0] d;
        bus_xfer(idx, 1'b1, {24'h00_0000, data}, d);
    endtask

    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus_xfer(idx, 1'b0, 32'h0000_0000, d);
        `CHK(d, {24'h00_0000, exp})
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Every register except transmit control, and one unmapped word, read zero after reset
    task automatic test_reset_values();
        logic [6:0] idx_list[12] = '{IDX_APPEND, IDX_PAUSE_HIGH, IDX_PAUSE_LOW, IDX_END_HIGH,
            IDX_END_LOW, IDX_START_HIGH, IDX_START_LOW, IDX_FRAME_KIND, IDX_WIRE_HIGH,
            IDX_WIRE_LOW, IDX_ABORT_FLAGS, 7'h40};
        for (int i = 0; i < 12; i++) begin
            rd_chk(idx_list[i], 8'h00);
        end
        `CHK(hresp, HRESP_OKAY)
        $display("test_reset_values done");
    endtask

    task automatic test_pause_quantum();
        logic [31:0] d;
        wr8(IDX_PAUSE_HIGH, 8'hA5);
        wr8(IDX_PAUSE_LOW, 8'h3C);
        rd_chk(IDX_PAUSE_HIGH, 8'hA5);
        `CHK(pause_quantum, 16'hA53C)
        // Upper lanes carry junk: only the low byte may land
        bus_xfer(IDX_PAUSE_LOW, 1'b1, 32'hFFFF_FF5A, d);
        rd_chk(IDX_PAUSE_LOW, 8'h5A);
        `CHK(pause_quantum, 16'hA55A)
        $display("test_pause_quantum done");
    endtask

    // Enable low: a bus write must not land anywhere
    task automatic test_freeze();
        ce <= 1'b0;
        wr8(IDX_PAUSE_HIGH, 8'h11);
        ce <= 1'b1;
        rd_chk(IDX_PAUSE_HIGH, 8'hA5);
        `CHK(pause_quantum, 16'hA55A)
        $display("test_freeze done");
    endtask

    task automatic test_append();
        wr8(IDX_START_HIGH, 8'h00);
        wr8(IDX_START_LOW, 8'h00);
        cap_addr.delete();
        cap_data.delete();
        for (int i = 0; i < 3; i++) begin
            wr8(IDX_APPEND, 8'hC0 + 8'(i));
        end
        repeat (2) @(posedge hclk);
        `CHK(cap_addr.size(), 3)
        for (int i = 0; i < 3; i++) begin
            `CHK(cap_addr[i], 16'(i))
            `CHK(cap_data[i], 8'hC0 + 8'(i))
        end
        rd_chk(IDX_END_HIGH, 8'h00);
        rd_chk(IDX_END_LOW, 8'h02);
        rd_chk(IDX_START_LOW, 8'h03);
        // Low byte at its top value: the carry must reach the high byte
        wr8(IDX_START_LOW, 8'hFF);
        wr8(IDX_APPEND, 8'h77);
        repeat (2) @(posedge hclk);
        `CHK(cap_addr[3], 16'h00FF)
        rd_chk(IDX_END_LOW, 8'hFF);
        rd_chk(IDX_START_HIGH, 8'h01);
        rd_chk(IDX_START_LOW, 8'h00);
        rd_chk(IDX_APPEND, 8'h00);
        wr8(IDX_START_HIGH, 8'h00);
        $display("test_append done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Each status source alone, plus pairs that depend on each other
    task automatic test_status();
        logic [11:0] f;
        int go_before;
        for (int i = 0; i < 14; i++) begin
            f = cases[i];
            plan_flags <= f;
            plan_bytes <= {8'(i), 8'hF0 - 8'(i)};
            latency <= (i % 2 == 0) ? 8'h14 : 8'h01;
            go_before = n_go;
            wr8(IDX_TX_CONTROL, {4'h0, f[9], f[10], 2'b01});
            if (i == 0) begin
                wr8(IDX_TX_CONTROL, 8'h01);
            end
            for (int k = 0; k < 60 && mac_tx_done !== 1'b1; k++) @(posedge hclk);
            `CHK(mac_tx_done, 1'b1)
            `CHK(pause_packet_request, f[9])
            `CHK(backpressure_request, f[10])
            repeat (2) @(posedge hclk);
            `CHK(n_go - go_before, 1)
            `CHK(pause_packet_request, 1'b0)
            wr8(IDX_FRAME_KIND, 8'hFF);
            rd_chk(IDX_FRAME_KIND, {4'h0, ~f[11], f[10], f[9] & f[8], f[8]});
            rd_chk(IDX_WIRE_HIGH, 8'(i));
            rd_chk(IDX_WIRE_LOW, 8'hF0 - 8'(i));
            rd_chk(IDX_ABORT_FLAGS, {f[7:3], f[2] & ~|f[7:3], f[1:0]});
        end
        $display("test_status done");
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset_values();
        test_pause_quantum();
        test_freeze();
        test_append();
        test_status();
        wrap_up();
    end
endmodule // tb_eth_tx_buffer_pause_status_regs
